/* ees_host_model.sv */
// spi host model in mode 0 driving the eeprom pins
`timescale 1ns/1ns
module ees_host_model (
  input  wire logic clk_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  output logic      hold_n_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  logic oe_seen;
  logic last_b;
  logic cs_q;

  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    hold_n_o = 1'b1;
    last_b = 1'b0;
  end

  // sticky per selection, cleared at each chip select fall; one process owns it
  always @(posedge clk_i) begin
    cs_q <= cs_n_o;
    if (cs_q && !cs_n_o) oe_seen <= 1'b0;
    else if (!cs_n_o && so_oe_i) oe_seen <= 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic sel();
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    tick(4);
  endtask

  // clock stands still low between frames
  task automatic desel();
    sck_o <= 1'b0;
    tick(4);
    cs_n_o <= 1'b1;
    si_o <= ~si_o;
    tick(6);
  endtask

  // sample late in the high phase, long after the device launched the bit
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_o <= 1'b0;
      si_o <= tx[i];
      tick(4);
      sck_o <= 1'b1;
      tick(4);
      rx[i] = so_oe_i ? so_i : ~last_b;
      last_b = rx[i];
    end
  endtask

  task automatic pause(input int n, output logic oe_h);
    oe_h = 1'b0;
    sck_o <= 1'b0;
    tick(4);
    hold_n_o <= 1'b0;
    for (int k = 0; k < n; k++) begin
      si_o <= ~si_o;
      tick(1);
      if (k > 3) oe_h = oe_h | so_oe_i;
    end
    hold_n_o <= 1'b1;
    tick(4);
  endtask
endmodule

/* ees_pkg.sv */
// shared constants, types and helpers for the serial eeprom command engine
package ees_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T_WRITE_NS    = 5000000;
  localparam int unsigned WRITE_CYCLES  = T_WRITE_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W       = 20;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned PAGE_W     = 5;
  localparam int unsigned MEM_DEPTH  = 4096;
  localparam int unsigned PAGE_BYTES = 32;

  // ************************************************************
  // opcodes, msb first
  // ************************************************************
  localparam logic [7:0] LATCH_SET_CMD    = 8'h06;
  localparam logic [7:0] LATCH_CLR_CMD    = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD  = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] ARRAY_READ_CMD   = 8'h03;
  localparam logic [7:0] ARRAY_WRITE_CMD  = 8'h02;

  // ************************************************************
  // status byte layout and reset values
  // ************************************************************
  localparam int unsigned SR_PIN_EN_BIT = 7;
  localparam int unsigned SR_BP_HI_BIT  = 3;
  localparam int unsigned SR_BP_LO_BIT  = 2;
  localparam int unsigned SR_WEL_BIT    = 1;
  localparam int unsigned SR_BUSY_BIT   = 0;
  localparam logic        PIN_EN_RST    = 1'b0;
  localparam logic [1:0]  BP_RST        = 2'b00;
  localparam logic        WEL_RST       = 1'b0;

  // ************************************************************
  // pin synchroniser layout: {cs_n, sck, si, hold_n, wp_n}
  // ************************************************************
  localparam int unsigned PIN_N     = 5;
  localparam logic [4:0]  PIN_RST   = 5'h13;
  localparam int unsigned PIN_CS    = 4;
  localparam int unsigned PIN_SCK   = 3;
  localparam int unsigned PIN_SI    = 2;
  localparam int unsigned PIN_HOLD  = 1;
  localparam int unsigned PIN_WP    = 0;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_RD_OUT, ST_SR_OUT,
    ST_SR_IN, ST_SR_DONE, ST_WR_DATA, ST_CMD_DONE, ST_IGNORE
  } ees_state_e;

  // block protection by page: quarter, half or whole array
  function automatic logic blk_prot(input logic [1:0] bp, input logic [6:0] page);
    case (bp)
      2'b01:   blk_prot = (page[6:5] == 2'b11);
      2'b10:   blk_prot = page[6];
      2'b11:   blk_prot = 1'b1;
      default: blk_prot = 1'b0;
    endcase
  endfunction

endpackage

/* ees_spi_eeprom.sv */
// serial eeprom command engine: selection, status register, array access, hold
`timescale 1ns/1ns
// ************************************************************
// Contract
// - status write changes only bits 7, 3 and 2
// - status byte: pin enable, three zeros, block protect, latch, busy
// - 8-bit opcodes msb first: 05 status read, 01 status write, 03 read
// - pin enable set and protect pin low refuses status write
// - protect pin falling while selected aborts a status write
// - protect pin has no effect once the write cycle started
// - pin enable clear means protect pin level is ignored
// - only the low 12 address bits are used
// - data shifts out right after the last address bit, continuing
// - read pointer increments per byte and wraps to zero
// - read ends only at chip select high; output then released
// - status read accepted any time, status byte shifted out
// - status read during write cycle returns the full byte
// - in hold: output released, input ignored, position kept
// - after reset: standby with write enable latch cleared
// - completed array or status write clears write enable latch
// - write cycle starts at chip select high after whole bytes only
// - array access during write cycle is ignored
// - unknown opcode ignored, output stays released for that selection
// ************************************************************
module ees_spi_eeprom #(
  parameter int unsigned WRITE_CYCLES_P = ees_pkg::WRITE_CYCLES
) (
  input  logic       clk_i,
  input  logic       resetn_i,
  input  logic       cs_n_i,
  input  logic       sck_i,
  input  logic       si_i,
  input  logic       hold_n_i,
  input  logic       wp_n_i,
  output logic       so_o,
  output logic       so_oe_o,
  output logic       busy_o,
  output logic [7:0] status_o
);
  import ees_pkg::*;

  // ************************************************************
  // declarations
  // ************************************************************
  logic [PIN_N-1:0]  pins_s;
  logic              cs_n_s;
  logic              sck_s;
  logic              si_s;
  logic              hold_n_s;
  logic              wp_n_s;
  logic              sck_q_ff;
  logic              cs_q_ff;
  logic              wp_q_ff;
  logic              shift_en;
  logic              sck_rise;
  logic              sck_fall;
  logic              sel_start;
  logic              sel_end;
  logic              wp_fall;
  logic              byte_done;
  logic [7:0]        rx_byte;
  logic [7:0]        tx_byte;

  ees_state_e        state_ff;
  ees_state_e        nxt_state;
  logic [2:0]        bit_cnt_ff;
  logic [7:0]        in_sh_ff;
  logic [7:0]        opc_ff;
  logic              addr_hi_ff;
  logic [ADDR_W-1:0] addr_ff;

  logic              so_ff;
  logic [7:0]        out_sh_ff;
  logic [2:0]        out_cnt_ff;
  logic              oe_ff;

  logic              pin_en_ff;
  logic [1:0]        bp_ff;
  logic              wel_ff;
  logic [7:0]        sr_new_ff;
  logic              abort_ff;
  logic              wc_sr_ff;
  logic              hw_prot;
  logic              sr_start;
  logic              pg_start;
  logic              wc_start;
  logic              wc_busy;
  logic              wc_done;
  logic [7:0]        status_byte;

  logic [7:0]        mem      [0:MEM_DEPTH-1];
  logic [7:0]        pbuf     [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] pmask_ff;
  logic [PAGE_W-1:0] cw_idx_ff;

  // ************************************************************
  // pin sampling and edge detection
  // ************************************************************
  ees_sync #(
    .W       (PIN_N),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      ({cs_n_i, sck_i, si_i, hold_n_i, wp_n_i}),
    .q_o      (pins_s)
  );

  assign cs_n_s   = pins_s[PIN_CS];
  assign sck_s    = pins_s[PIN_SCK];
  assign si_s     = pins_s[PIN_SI];
  assign hold_n_s = pins_s[PIN_HOLD];
  assign wp_n_s   = pins_s[PIN_WP];

  // deselected at reset, so a chip select held low through reset is seen as a fresh fall once synchronised
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_q_ff <= PIN_RST[PIN_SCK];
      cs_q_ff  <= PIN_RST[PIN_CS];
      wp_q_ff  <= PIN_RST[PIN_WP];
    end else begin
      sck_q_ff <= sck_s;
      cs_q_ff  <= cs_n_s;
      wp_q_ff  <= wp_n_s;
    end
  end

  // clock edges only count while selected and not held
  assign shift_en  = hold_n_s & ~cs_n_s;
  assign sck_rise  = shift_en & sck_s & ~sck_q_ff;
  assign sck_fall  = shift_en & ~sck_s & sck_q_ff;
  assign sel_start = cs_q_ff & ~cs_n_s;
  assign sel_end   = ~cs_q_ff & cs_n_s;
  assign wp_fall   = wp_q_ff & ~wp_n_s;
  assign byte_done = sck_rise && (bit_cnt_ff == 3'd7);
  assign rx_byte   = {in_sh_ff[6:0], si_s};

  // ************************************************************
  // command sequencing
  // ************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OPC: begin
        if (rx_byte == STATUS_READ_CMD) begin
          nxt_state = ST_SR_OUT;
        end else if (wc_busy) begin
          nxt_state = ST_IGNORE;
        end else begin
          case (rx_byte)
            ARRAY_READ_CMD:   nxt_state = ST_ADDR;
            ARRAY_WRITE_CMD:  nxt_state = ST_ADDR;
            STATUS_WRITE_CMD: nxt_state = ST_SR_IN;
            LATCH_SET_CMD:    nxt_state = ST_CMD_DONE;
            LATCH_CLR_CMD:    nxt_state = ST_CMD_DONE;
            default:          nxt_state = ST_IGNORE;
          endcase
        end
      end
      ST_ADDR: begin
        if (addr_hi_ff) begin
          nxt_state = (opc_ff == ARRAY_READ_CMD) ? ST_RD_OUT : ST_WR_DATA;
        end
      end
      ST_SR_IN:    nxt_state = ST_SR_DONE;
      ST_SR_DONE:  nxt_state = ST_IGNORE;
      ST_CMD_DONE: nxt_state = ST_IGNORE;
      default:     nxt_state = state_ff;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= 3'd0;
      in_sh_ff   <= 8'h00;
      opc_ff     <= 8'h00;
      addr_hi_ff <= 1'b0;
    end else if (sel_start) begin
      state_ff   <= ST_OPC;
      bit_cnt_ff <= 3'd0;
      addr_hi_ff <= 1'b0;
    end else if (sel_end) begin
      state_ff <= ST_IDLE;
    end else begin
      if (sck_rise) begin
        in_sh_ff   <= rx_byte;
        bit_cnt_ff <= bit_cnt_ff + 3'd1;
      end
      if (byte_done) begin
        state_ff <= nxt_state;
      end
      if (byte_done && state_ff == ST_OPC) begin
        opc_ff <= rx_byte;
      end
      if (byte_done && state_ff == ST_ADDR) begin
        addr_hi_ff <= 1'b1;
      end
    end
  end

  // address pointer: loaded from the address bytes, stepped by reads and loads
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_ff <= '0;
    end else if (!cs_n_s && !sel_start) begin
      if (byte_done && state_ff == ST_ADDR) begin
        if (!addr_hi_ff) begin
          addr_ff[11:8] <= rx_byte[3:0];
        end else begin
          addr_ff[7:0] <= rx_byte;
        end
      end else if (byte_done && state_ff == ST_WR_DATA) begin
        // rolls within the page; the page part never moves
        addr_ff[PAGE_W-1:0] <= addr_ff[PAGE_W-1:0] + PAGE_W'(1);
      end else if (sck_fall && state_ff == ST_RD_OUT && out_cnt_ff == 3'd7) begin
        addr_ff <= addr_ff + ADDR_W'(1);
      end
    end
  end

  // ************************************************************
  // serial output
  // ************************************************************
  assign status_byte = {pin_en_ff, 3'b000, bp_ff, wel_ff, wc_busy};
  assign tx_byte     = (state_ff == ST_SR_OUT) ? status_byte : mem[addr_ff];

  // new bit on each falling clock; mode 0 and mode 3 both see it before the rise
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      so_ff      <= 1'b0;
      out_sh_ff  <= 8'h00;
      out_cnt_ff <= 3'd0;
      oe_ff      <= 1'b0;
    end else if (sel_start || sel_end) begin
      out_cnt_ff <= 3'd0;
      oe_ff      <= 1'b0;
    end else if (sck_fall && (state_ff == ST_RD_OUT || state_ff == ST_SR_OUT)) begin
      oe_ff      <= 1'b1;
      out_cnt_ff <= out_cnt_ff + 3'd1;
      if (out_cnt_ff == 3'd0) begin
        so_ff     <= tx_byte[7];
        out_sh_ff <= {tx_byte[6:0], 1'b0};
      end else begin
        so_ff     <= out_sh_ff[7];
        out_sh_ff <= {out_sh_ff[6:0], 1'b0};
      end
    end
  end

  assign so_o    = so_ff;
  // released at once on hold, no waiting for a clock edge
  assign so_oe_o = oe_ff & hold_n_s & ~cs_n_s;

  // ************************************************************
  // status register, write enable latch and protection
  // ************************************************************
  assign hw_prot = pin_en_ff & ~wp_n_s;

  // a status write needs exactly opcode plus one byte, whole bits only
  assign sr_start = sel_end && state_ff == ST_SR_DONE && bit_cnt_ff == 3'd0 && wel_ff
                    && !hw_prot && !abort_ff && !wc_busy;
  assign pg_start = sel_end && state_ff == ST_WR_DATA && bit_cnt_ff == 3'd0 && wel_ff
                    && (|pmask_ff) && !wc_busy
                    && !blk_prot(bp_ff, addr_ff[ADDR_W-1:PAGE_W]);
  assign wc_start = sr_start | pg_start;

  // protect pin falling mid-command kills the pending status write
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      abort_ff <= 1'b0;
    end else if (sel_start) begin
      abort_ff <= 1'b0;
    end else if (!cs_n_s && wp_fall && pin_en_ff
                 && (state_ff == ST_SR_IN || state_ff == ST_SR_DONE)) begin
      abort_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sr_new_ff <= 8'h00;
    end else if (byte_done && state_ff == ST_SR_IN) begin
      sr_new_ff <= rx_byte;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wc_sr_ff <= 1'b0;
    end else if (wc_start) begin
      wc_sr_ff <= sr_start;
    end
  end

  // new protect bits land as busy drops; pin changes after the start do nothing
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_en_ff <= PIN_EN_RST;
      bp_ff     <= BP_RST;
    end else if (wc_done && wc_sr_ff) begin
      pin_en_ff <= sr_new_ff[SR_PIN_EN_BIT];
      bp_ff     <= {sr_new_ff[SR_BP_HI_BIT], sr_new_ff[SR_BP_LO_BIT]};
    end
  end

  // latch commands take effect only at a clean deselect after eight bits
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wel_ff <= WEL_RST;
    end else if (wc_done) begin
      wel_ff <= 1'b0;
    end else if (sel_end && state_ff == ST_CMD_DONE && bit_cnt_ff == 3'd0) begin
      wel_ff <= (opc_ff == LATCH_SET_CMD);
    end
  end

  ees_wtimer #(
    .CYCLES (WRITE_CYCLES_P)
  ) u_wtimer (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .start_i  (wc_start),
    .busy_o   (wc_busy),
    .done_o   (wc_done)
  );

  assign busy_o   = wc_busy;
  assign status_o = status_byte;

  // ************************************************************
  // page buffer and array programming
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (byte_done && state_ff == ST_WR_DATA) begin
      pbuf[addr_ff[PAGE_W-1:0]] <= rx_byte;
    end
  end

  // mask kept through the write cycle; a status read then must not wipe it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pmask_ff <= '0;
    end else if (sel_start && !wc_busy) begin
      pmask_ff <= '0;
    end else if (byte_done && state_ff == ST_WR_DATA) begin
      pmask_ff[addr_ff[PAGE_W-1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cw_idx_ff <= '0;
    end else if (wc_start) begin
      cw_idx_ff <= '0;
    end else if (wc_busy) begin
      cw_idx_ff <= cw_idx_ff + PAGE_W'(1);
    end
  end

  // one page byte per clock; the cycle is far longer than a page sweep
  always_ff @(posedge clk_i) begin
    if (wc_busy && !wc_sr_ff && pmask_ff[cw_idx_ff]) begin
      mem[{addr_ff[ADDR_W-1:PAGE_W], cw_idx_ff}] <= pbuf[cw_idx_ff];
    end
  end

endmodule

/* ees_spi_eeprom_props.sv */
// concurrent checks on the pins of the serial eeprom command engine
`timescale 1ns/1ns
module ees_spi_eeprom_props (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       cs_n_i,
  input wire logic       sck_i,
  input wire logic       si_i,
  input wire logic       hold_n_i,
  input wire logic       wp_n_i,
  input wire logic       so_o,
  input wire logic       so_oe_o,
  input wire logic       busy_o,
  input wire logic [7:0] status_o
);
  // ************************************************************
  // properties, all in the system clock domain
  // ************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // pin sync delay is two clocks, so six gives margin
  a_oe_desel: assert property (cs_n_i [*6] |-> !so_oe_o)
    else $error("serial output driven while deselected");
  a_oe_hold: assert property (!hold_n_i [*5] |-> !so_oe_o)
    else $error("serial output driven during hold");
  a_zero_bits: assert property (status_o[6:4] == 3'h0)
    else $error("status bits 6 to 4 not zero");
  a_start_wel: assert property ($rose(busy_o) |-> status_o[1])
    else $error("write cycle began without write enable latch set");
  a_sr_frozen: assert property ($changed({status_o[7], status_o[3:2]}) |-> $fell(busy_o))
    else $error("protect bits changed outside end of write cycle");
  a_wel_done: assert property ($fell(busy_o) |-> !status_o[1])
    else $error("write enable latch still set after write cycle");
  a_busy_cs: assert property ($rose(busy_o) |-> $past(cs_n_i, 2))
    else $error("write cycle began without chip select rise");
  a_busy_sel: assert property (!cs_n_i [*6] |-> !$rose(busy_o))
    else $error("write cycle began while selected");
  a_busy_ends: assert property ($rose(busy_o) |-> ##[1:1000] !busy_o)
    else $error("write cycle never finished");

  c_write: cover property ($rose(busy_o));
  c_read: cover property ($rose(so_oe_o));
  c_hold: cover property (!hold_n_i && !cs_n_i);
endmodule

/* ees_sync.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module ees_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  logic         clk_i,
  input  logic         resetn_i,
  input  logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage is read by the second stage only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule

/* ees_wtimer.sv */
// self-timed write cycle counter
`timescale 1ns/1ns
module ees_wtimer #(
  parameter int unsigned CYCLES = ees_pkg::WRITE_CYCLES
) (
  input  logic clk_i,
  input  logic resetn_i,
  input  logic start_i,
  output logic busy_o,
  output logic done_o
);
  import ees_pkg::*;

  logic [TIMER_W-1:0] cnt_ff;
  logic               busy_ff;

  // a start while busy is dropped: the running cycle is never disturbed
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_ff <= 1'b0;
      cnt_ff  <= '0;
    end else if (start_i && !busy_ff) begin
      busy_ff <= 1'b1;
      cnt_ff  <= TIMER_W'(CYCLES - 1);
    end else if (busy_ff) begin
      if (cnt_ff == '0) begin
        busy_ff <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff - TIMER_W'(1);
      end
    end
  end

  assign busy_o = busy_ff;
  // last busy cycle, so results land on the edge where busy drops
  assign done_o = busy_ff && (cnt_ff == '0);
endmodule

/* tb_top.sv */
// self-checking bench for the serial eeprom command engine
`timescale 1ns/1ns
module tb_top;
  import ees_pkg::*;
  // ************************************************************
  // pins and instances
  // ************************************************************
  logic       clk_i;
  logic       resetn_i;
  logic       wp_n;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       hold_n;
  logic       so;
  logic       so_oe;
  logic       busy;
  logic [7:0] status;
  int         err_total;
  int         n_tests;

  // long enough that a status read fits inside one write cycle
  ees_spi_eeprom #(.WRITE_CYCLES_P(400)) u_ees_spi_eeprom (
    .clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe), .busy_o(busy),
    .status_o(status)
  );
  ees_host_model u_ees_host_model (
    .clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .hold_n_o(hold_n),
    .so_i(so), .so_oe_i(so_oe)
  );

  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude();
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic frame(input int n, input logic [31:0] w, output logic [7:0] r);
    u_ees_host_model.sel();
    for (int i = 0; i < n; i++) u_ees_host_model.xbyte(w[31-8*i -: 8], r);
    u_ees_host_model.desel();
  endtask

  task automatic status_read_cmd(output logic [7:0] r);
    frame(2, {STATUS_READ_CMD, 24'h0}, r);
  endtask

  task automatic latch_set_cmd();
    logic [7:0] r;
    frame(1, {LATCH_SET_CMD, 24'h0}, r);
  endtask

  task automatic wait_ready();
    logic [7:0] r;
    r = 8'h01;
    for (int k = 0; k < 20 && r[0] !== 1'b0; k++) status_read_cmd(r);
    chk("ready", {7'h0, r[0]}, 8'h00);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    logic [7:0] r;
    chk("status_rst", status, 8'h00);
    status_read_cmd(r);
    chk("status_read_cmd_rst", r, 8'h00);
  endtask

  // protect pin low but its enable clear: write must still land
  task automatic t_status();
    logic [7:0] r;
    logic       oh;
    wp_n <= 1'b0;
    latch_set_cmd();
    status_read_cmd(r);
    chk("wel_set", r, 8'h02);
    frame(2, {STATUS_WRITE_CMD, 8'hff, 16'h0}, r);
    status_read_cmd(r);
    chk("status_read_cmd_busy", r, 8'h03);
    wait_ready();
    u_ees_host_model.sel();
    u_ees_host_model.xbyte(STATUS_READ_CMD, r);
    u_ees_host_model.pause(12, oh);
    chk("hold_oe", {7'h0, oh}, 8'h00);
    u_ees_host_model.xbyte(8'h00, r);
    u_ees_host_model.desel();
    chk("sr_written", r, 8'h8c);
  endtask

  task automatic t_protect();
    logic [7:0] r;
    latch_set_cmd();
    frame(2, {STATUS_WRITE_CMD, 8'h00, 16'h0}, r);
    chk("refused_busy", {7'h0, busy}, 8'h00);
    status_read_cmd(r);
    chk("refused_sr", r, 8'h8e);
    wp_n <= 1'b1;
    u_ees_host_model.sel();
    u_ees_host_model.xbyte(STATUS_WRITE_CMD, r);
    wp_n <= 1'b0;
    u_ees_host_model.tick(8);
    wp_n <= 1'b1;
    u_ees_host_model.xbyte(8'h00, r);
    u_ees_host_model.desel();
    chk("abort_busy", {7'h0, busy}, 8'h00);
    status_read_cmd(r);
    chk("abort_sr", r, 8'h8e);
    frame(2, {STATUS_WRITE_CMD, 8'h00, 16'h0}, r);
    wp_n <= 1'b0;
    wait_ready();
    status_read_cmd(r);
    chk("late_wp_sr", r, 8'h00);
    wp_n <= 1'b1;
  endtask

  task automatic t_array();
    logic [7:0] r;
    latch_set_cmd();
    frame(4, {ARRAY_WRITE_CMD, 16'h0fff, 8'ha5}, r);
    wait_ready();
    latch_set_cmd();
    frame(4, {ARRAY_WRITE_CMD, 16'h0000, 8'h3c}, r);
    frame(4, {ARRAY_READ_CMD, 24'h0}, r);
    chk("busy_read_oe", {7'h0, u_ees_host_model.oe_seen}, 8'h00);
    wait_ready();
    u_ees_host_model.sel();
    u_ees_host_model.xbyte(ARRAY_READ_CMD, r);
    u_ees_host_model.xbyte(8'hff, r);
    u_ees_host_model.xbyte(8'hff, r);
    u_ees_host_model.xbyte(8'h00, r);
    chk("rd_top", r, 8'ha5);
    u_ees_host_model.xbyte(8'h00, r);
    chk("rd_wrap", r, 8'h3c);
    u_ees_host_model.desel();
    chk("rd_release", {7'h0, so_oe}, 8'h00);
  endtask

  task automatic t_badop();
    logic [7:0] r;
    latch_set_cmd();
    u_ees_host_model.sel();
    u_ees_host_model.xbyte(8'ha7, r);
    u_ees_host_model.xbyte(8'h00, r);
    chk("bad_oe", {7'h0, u_ees_host_model.oe_seen}, 8'h00);
    u_ees_host_model.desel();
    status_read_cmd(r);
    chk("after_bad", r, 8'h02);
    frame(1, {LATCH_CLR_CMD, 24'h0}, r);
    status_read_cmd(r);
    chk("latch_clr", r, 8'h00);
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    err_total = 0;
    n_tests = 0;
    resetn_i = 1'b0;
    wp_n = 1'b1;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_status();
    t_protect();
    t_array();
    t_badop();
    conclude();
  end

  // roughly seven times the expected run length
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    conclude();
  end
endmodule

bind ees_spi_eeprom ees_spi_eeprom_props u_props (
  .clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i),
  .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
  .busy_o(busy_o), .status_o(status_o)
);
